/* File: cps_pkg.sv */
/*
 * constants, enumerations and carrier structs of the cyclic process-data
 * register bank: register codes, write-enable bit positions, mode values
 * and slot sizes.
 * assumes: one clock, fieldbus stack and device core on that same clock.
 */
// What this block does
// - one input slot, one output slot only
// - each sub-slot carries exactly one register
// - input slot holds at most 20 sub-slots
// - output slot holds at most 12 sub-slots
// - registers may sit in any sub-slot order
// - both slots exchanged every fieldbus cycle
// - write-enable mask cleared at power-up
// - changed value with mask bit clear ignored
// - mask bits 0..12 map to output registers
// - alarm bitmap readable at 0x000c
// - enabled error clear clears hardware error bits
// - flow setpoint float, used in flow mode
// - pressure setpoint float, used in pressure mode
// - actual pressure only valid with transmitter fitted
// - serial number read-only 32-bit at 0x001e
// - setpoint storage enable saves setpoint to nonvolatile
// - enabled software restart write resets device
// - enabled backup restore write restores saved configuration
// - ramp time sets setpoint transition duration
// - table select picks one calibrated table
// - two presets select flow and pressure loop tuning
// - cyclic exchange only, no acyclic access
// - serial-port settings appear only after power cycle
// - output register acts only on value change
package cps_pkg;
   // ==========================================================
   // slot sizes
   localparam int unsigned IN_SUBSLOTS = 20;
   localparam int unsigned OUT_SUBSLOTS = 12;
   localparam int unsigned MASK_BITS = 13;

   // ==========================================================
   // register codes
   localparam logic [15:0] ADDR_ACTUAL_FLOW = 16'h0000;
   localparam logic [15:0] ADDR_GAS_TEMPERATURE = 16'h0002;
   localparam logic [15:0] ADDR_ACCUMULATED_VOLUME = 16'h0004;
   localparam logic [15:0] ADDR_FLOW_SETPOINT = 16'h0006;
   localparam logic [15:0] ADDR_VALVE_DRIVE = 16'h000a;
   localparam logic [15:0] ADDR_ALARM_BITMAP = 16'h000c;
   localparam logic [15:0] ADDR_HW_ERROR_STATE = 16'h000d;
   localparam logic [15:0] ADDR_CONTROL_MODE = 16'h000e;
   localparam logic [15:0] ADDR_RAMP_TIME = 16'h000f;
   localparam logic [15:0] ADDR_FLOW_UNIT = 16'h0016;
   localparam logic [15:0] ADDR_GAS_NAME = 16'h001a;
   localparam logic [15:0] ADDR_SERIAL_NUMBER = 16'h001e;
   localparam logic [15:0] ADDR_INSTR_CODE_A = 16'h0023;
   localparam logic [15:0] ADDR_SOFTWARE_RESTART = 16'h0034;
   localparam logic [15:0] ADDR_FLOW_LOOP_PRESET = 16'h0035;
   localparam logic [15:0] ADDR_BACKUP_RESTORE = 16'h0037;
   localparam logic [15:0] ADDR_MAX_FLOW = 16'h094f;
   localparam logic [15:0] ADDR_INSTR_CODE_B = 16'h1004;
   localparam logic [15:0] ADDR_VOLUME_UNIT = 16'h4048;
   localparam logic [15:0] ADDR_HW_ERROR_CLEAR = 16'h404f;
   localparam logic [15:0] ADDR_SP_PERSIST = 16'h4050;
   localparam logic [15:0] ADDR_CAL_TABLE = 16'h4139;
   localparam logic [15:0] ADDR_ACTUAL_PRESSURE = 16'h5f00;
   localparam logic [15:0] ADDR_PRES_LOW_LIMIT = 16'h5f02;
   localparam logic [15:0] ADDR_PRES_HIGH_LIMIT = 16'h5f04;
   localparam logic [15:0] ADDR_PRESSURE_SETPOINT = 16'h5f06;
   localparam logic [15:0] ADDR_PRESSURE_UNIT = 16'h5f08;
   localparam logic [15:0] ADDR_PRES_LOOP_PRESET = 16'h5f10;
   localparam logic [15:0] ADDR_WRITE_ENABLE_MASK = 16'hfff0;

   // ==========================================================
   // write-enable mask bit positions
   localparam logic [3:0] BIT_TOTALIZER = 4'h0;
   localparam logic [3:0] BIT_FLOW_SP = 4'h1;
   localparam logic [3:0] BIT_VALVE = 4'h2;
   localparam logic [3:0] BIT_MODE = 4'h3;
   localparam logic [3:0] BIT_RAMP = 4'h4;
   localparam logic [3:0] BIT_FLOW_PID = 4'h5;
   localparam logic [3:0] BIT_RESTORE = 4'h6;
   localparam logic [3:0] BIT_HW_CLEAR = 4'h7;
   localparam logic [3:0] BIT_PERSIST = 4'h8;
   localparam logic [3:0] BIT_CAL_TABLE = 4'h9;
   localparam logic [3:0] BIT_PRES_SP = 4'ha;
   localparam logic [3:0] BIT_PRES_PID = 4'hb;
   localparam logic [3:0] BIT_RESTART = 4'hc;
   localparam logic [3:0] BIT_IS_MASK = 4'hf;

   // ==========================================================
   // control modes and reset values
   localparam logic [15:0] MODE_FLOW = 16'h0001;
   localparam logic [15:0] MODE_PRESSURE = 16'h0005;
   localparam logic [12:0] MASK_RST = 13'h0000;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      PH_SNAP = 2'b00,
      PH_IDLE = 2'b01,
      PH_RUN = 2'b11,
      PH_FAULT = 2'b10
   } cps_phase_t;

   typedef struct packed {
      logic [31:0] flow;
      logic [31:0] temp;
      logic [31:0] total;
      logic [31:0] valve;
      logic [31:0] pressure;
      logic [15:0] alarms;
      logic [15:0] hw_err_set;
      logic pres_fitted;
   } cps_meas_t;

   typedef struct packed {
      logic [63:0] flow_unit;
      logic [63:0] gas_name;
      logic [63:0] code_a;
      logic [63:0] code_b;
      logic [63:0] vol_unit;
      logic [63:0] pres_unit;
      logic [31:0] serial;
      logic [31:0] max_flow;
      logic [31:0] pres_lo;
      logic [31:0] pres_hi;
   } cps_ident_t;

   typedef struct packed {
      logic [31:0] flow_sp;
      logic [31:0] pres_sp;
      logic [31:0] active_sp;
      logic [31:0] valve;
      logic [31:0] tot_val;
      logic [15:0] mode;
      logic [15:0] ramp;
      logic [15:0] flow_pid;
      logic [15:0] pres_pid;
      logic [15:0] cal_table;
      logic [15:0] persist;
      logic [15:0] hw_err_state;
      logic tot_load;
      logic sp_save;
      logic soft_restart;
      logic restore;
   } cps_ctl_t;
endpackage : cps_pkg

/* File: cps_regbank.sv */
/*
 * cyclic process-data register bank: maps registers onto input and output
 * sub-slots, gates output writes by the write-enable mask and drives the
 * device core's settings and action pulses.
 * assumes: fieldbus stack gives one cycle strobe per exchange and the
 * slot configuration as a strobed word set, all on CLK_IN.
 */
module cps_regbank #(
   parameter int unsigned N_IN = cps_pkg::IN_SUBSLOTS,
   parameter int unsigned N_OUT = cps_pkg::OUT_SUBSLOTS
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CFG_STB_IN,
   input wire logic [$clog2(N_IN+1)-1:0] IN_CNT_IN,
   input wire logic [$clog2(N_OUT+1)-1:0] OUT_CNT_IN,
   input wire logic [N_IN-1:0][15:0] IN_MAP_IN,
   input wire logic [N_OUT-1:0][15:0] OUT_MAP_IN,
   input wire logic CYC_STB_IN,
   input wire logic [N_OUT-1:0][31:0] OUT_SLOT_IN,
   input wire cps_pkg::cps_meas_t MEAS_IN,
   input wire cps_pkg::cps_ident_t IDENT_IN,
   output logic [N_IN-1:0][63:0] IN_SLOT_OUT,
   output logic SLOT_DONE_OUT,
   output cps_pkg::cps_ctl_t CTL_OUT,
   output logic [12:0] WR_MASK_OUT,
   output logic RUN_OUT,
   output logic CFG_ERR_OUT
);
   localparam int unsigned IW = $clog2(N_IN+1);
   localparam int unsigned OW = $clog2(N_OUT+1);

   // ==========================================================
   // state
   typedef struct packed {
      cps_pkg::cps_phase_t ph;
      cps_pkg::cps_ident_t ident;
      cps_pkg::cps_ctl_t ctl;
      logic [12:0] mask;
      logic [IW-1:0] in_cnt;
      logic [OW-1:0] out_cnt;
      logic [N_IN-1:0][15:0] in_map;
      logic [N_OUT-1:0][15:0] out_map;
      logic [N_OUT-1:0][31:0] last;
      logic [N_IN-1:0][63:0] inslot;
      logic done;
      logic cfg_err;
   } cps_state_t;

   localparam cps_state_t STATE_RST = '0;

   cps_state_t q;
   cps_state_t n;

   // ==========================================================
   // decoders
   // {known, bit index}; the mask itself reports BIT_IS_MASK
   function automatic logic [4:0] out_bit(input logic [15:0] code);
      logic [4:0] r;
      r = 5'h00;
      case (code)
         cps_pkg::ADDR_ACCUMULATED_VOLUME: r = {1'b1, cps_pkg::BIT_TOTALIZER};
         cps_pkg::ADDR_FLOW_SETPOINT: r = {1'b1, cps_pkg::BIT_FLOW_SP};
         cps_pkg::ADDR_VALVE_DRIVE: r = {1'b1, cps_pkg::BIT_VALVE};
         cps_pkg::ADDR_CONTROL_MODE: r = {1'b1, cps_pkg::BIT_MODE};
         cps_pkg::ADDR_RAMP_TIME: r = {1'b1, cps_pkg::BIT_RAMP};
         cps_pkg::ADDR_FLOW_LOOP_PRESET: r = {1'b1, cps_pkg::BIT_FLOW_PID};
         cps_pkg::ADDR_BACKUP_RESTORE: r = {1'b1, cps_pkg::BIT_RESTORE};
         cps_pkg::ADDR_HW_ERROR_CLEAR: r = {1'b1, cps_pkg::BIT_HW_CLEAR};
         cps_pkg::ADDR_SP_PERSIST: r = {1'b1, cps_pkg::BIT_PERSIST};
         cps_pkg::ADDR_CAL_TABLE: r = {1'b1, cps_pkg::BIT_CAL_TABLE};
         cps_pkg::ADDR_PRESSURE_SETPOINT: r = {1'b1, cps_pkg::BIT_PRES_SP};
         cps_pkg::ADDR_PRES_LOOP_PRESET: r = {1'b1, cps_pkg::BIT_PRES_PID};
         cps_pkg::ADDR_SOFTWARE_RESTART: r = {1'b1, cps_pkg::BIT_RESTART};
         cps_pkg::ADDR_WRITE_ENABLE_MASK: r = {1'b1, cps_pkg::BIT_IS_MASK};
         default: r = 5'h00;
      endcase
      return r;
   endfunction : out_bit

   // {known, value}; 16- and 32-bit values sit in the low bits
   function automatic logic [64:0] read_reg(
      input logic [15:0] code,
      input cps_pkg::cps_ctl_t c,
      input cps_pkg::cps_ident_t id,
      input cps_pkg::cps_meas_t m
   );
      logic [64:0] r;
      r = 65'h0;
      case (code)
         cps_pkg::ADDR_ACTUAL_FLOW: r = {33'h100000000, m.flow};
         cps_pkg::ADDR_GAS_TEMPERATURE: r = {33'h100000000, m.temp};
         cps_pkg::ADDR_ACCUMULATED_VOLUME: r = {33'h100000000, m.total};
         cps_pkg::ADDR_FLOW_SETPOINT: r = {33'h100000000, c.flow_sp};
         cps_pkg::ADDR_VALVE_DRIVE: r = {33'h100000000, m.valve};
         cps_pkg::ADDR_ALARM_BITMAP: r = {49'h1000000000000, m.alarms};
         cps_pkg::ADDR_HW_ERROR_STATE:
            r = {49'h1000000000000, c.hw_err_state};
         cps_pkg::ADDR_CONTROL_MODE: r = {49'h1000000000000, c.mode};
         cps_pkg::ADDR_RAMP_TIME: r = {49'h1000000000000, c.ramp};
         cps_pkg::ADDR_FLOW_UNIT: r = {1'b1, id.flow_unit};
         cps_pkg::ADDR_GAS_NAME: r = {1'b1, id.gas_name};
         cps_pkg::ADDR_SERIAL_NUMBER: r = {33'h100000000, id.serial};
         cps_pkg::ADDR_INSTR_CODE_A: r = {1'b1, id.code_a};
         cps_pkg::ADDR_FLOW_LOOP_PRESET:
            r = {49'h1000000000000, c.flow_pid};
         cps_pkg::ADDR_MAX_FLOW: r = {33'h100000000, id.max_flow};
         cps_pkg::ADDR_INSTR_CODE_B: r = {1'b1, id.code_b};
         cps_pkg::ADDR_VOLUME_UNIT: r = {1'b1, id.vol_unit};
         cps_pkg::ADDR_SP_PERSIST: r = {49'h1000000000000, c.persist};
         cps_pkg::ADDR_CAL_TABLE: r = {49'h1000000000000, c.cal_table};
         // no transmitter, no meaningful pressure: read as zero
         cps_pkg::ADDR_ACTUAL_PRESSURE:
            r = {33'h100000000, m.pres_fitted ? m.pressure : 32'h0};
         cps_pkg::ADDR_PRES_LOW_LIMIT: r = {33'h100000000, id.pres_lo};
         cps_pkg::ADDR_PRES_HIGH_LIMIT: r = {33'h100000000, id.pres_hi};
         cps_pkg::ADDR_PRESSURE_SETPOINT:
            r = {33'h100000000, c.pres_sp};
         cps_pkg::ADDR_PRESSURE_UNIT: r = {1'b1, id.pres_unit};
         cps_pkg::ADDR_PRES_LOOP_PRESET:
            r = {49'h1000000000000, c.pres_pid};
         default: r = 65'h0;
      endcase
      return r;
   endfunction : read_reg

   // ==========================================================
   // next state
   always_comb begin
      logic ok;
      logic [12:0] mask_v;
      logic [15:0] clr_v;
      logic [4:0] ob;
      logic [31:0] v;
      logic [64:0] rd;
      logic sp_hit;
      ok = 1'b1;
      mask_v = q.mask;
      clr_v = 16'h0000;
      ob = 5'h00;
      v = 32'h0;
      rd = 65'h0;
      sp_hit = 1'b0;
      n = q;
      n.done = 1'b0;
      n.ctl.tot_load = 1'b0;
      n.ctl.sp_save = 1'b0;
      n.ctl.soft_restart = 1'b0;
      n.ctl.restore = 1'b0;
      case (q.ph)
         // identity and units are frozen once after reset, so later
         // serial-port edits stay hidden until power is cycled
         cps_pkg::PH_SNAP: begin
            n.ident = IDENT_IN;
            n.ph = cps_pkg::PH_IDLE;
         end
         cps_pkg::PH_IDLE, cps_pkg::PH_RUN, cps_pkg::PH_FAULT: begin
            if (CFG_STB_IN) begin
               // only one slot of each kind exists: one map per direction
               if (IN_CNT_IN > IW'(N_IN)) begin
                  ok = 1'b0;
               end
               if (OUT_CNT_IN > OW'(N_OUT)) begin
                  ok = 1'b0;
               end
               // any order is fine, but every used sub-slot needs one
               // known register of the right direction
               for (int i = 0; i < N_IN; i++) begin
                  rd = read_reg(IN_MAP_IN[i], q.ctl, q.ident, MEAS_IN);
                  if (IW'(i) < IN_CNT_IN && !rd[64]) begin
                     ok = 1'b0;
                  end
               end
               for (int i = 0; i < N_OUT; i++) begin
                  ob = out_bit(OUT_MAP_IN[i]);
                  if (OW'(i) < OUT_CNT_IN && !ob[4]) begin
                     ok = 1'b0;
                  end
               end
               n.cfg_err = !ok;
               n.ph = ok ? cps_pkg::PH_RUN : cps_pkg::PH_FAULT;
               if (ok) begin
                  n.in_cnt = IN_CNT_IN;
                  n.out_cnt = OUT_CNT_IN;
                  n.in_map = IN_MAP_IN;
                  n.out_map = OUT_MAP_IN;
                  n.last = '0;
               end
            end else if (q.ph == cps_pkg::PH_RUN && CYC_STB_IN) begin
               // mask first, so a value arriving with its enable acts now
               for (int i = 0; i < N_OUT; i++) begin
                  if (OW'(i) < q.out_cnt &&
                      q.out_map[i] == cps_pkg::ADDR_WRITE_ENABLE_MASK) begin
                     mask_v = OUT_SLOT_IN[i][12:0];
                  end
               end
               n.mask = mask_v;
               for (int i = 0; i < N_OUT; i++) begin
                  ob = out_bit(q.out_map[i]);
                  v = OUT_SLOT_IN[i];
                  if (OW'(i) < q.out_cnt) begin
                     n.last[i] = v;
                  end
                  // repeating the same value does nothing, even zero
                  if (OW'(i) < q.out_cnt && v != q.last[i] &&
                      ob[3:0] != cps_pkg::BIT_IS_MASK &&
                      mask_v[ob[3:0]]) begin
                     case (ob[3:0])
                        cps_pkg::BIT_TOTALIZER: begin
                           n.ctl.tot_val = v;
                           n.ctl.tot_load = 1'b1;
                        end
                        cps_pkg::BIT_FLOW_SP: begin
                           n.ctl.flow_sp = v;
                           sp_hit = 1'b1;
                        end
                        cps_pkg::BIT_VALVE: n.ctl.valve = v;
                        cps_pkg::BIT_MODE: n.ctl.mode = v[15:0];
                        cps_pkg::BIT_RAMP: n.ctl.ramp = v[15:0];
                        cps_pkg::BIT_FLOW_PID:
                           n.ctl.flow_pid = v[15:0];
                        cps_pkg::BIT_RESTORE:
                           n.ctl.restore = 1'b1;
                        cps_pkg::BIT_HW_CLEAR:
                           clr_v = clr_v | v[15:0];
                        cps_pkg::BIT_PERSIST:
                           n.ctl.persist = v[15:0];
                        cps_pkg::BIT_CAL_TABLE:
                           n.ctl.cal_table = v[15:0];
                        cps_pkg::BIT_PRES_SP: begin
                           n.ctl.pres_sp = v;
                           sp_hit = 1'b1;
                        end
                        cps_pkg::BIT_PRES_PID:
                           n.ctl.pres_pid = v[15:0];
                        cps_pkg::BIT_RESTART:
                           n.ctl.soft_restart = 1'b1;
                        default: n.ctl.restore = n.ctl.restore;
                     endcase
                  end
               end
               // only cyclic reads exist: the slot is rebuilt each cycle
               for (int j = 0; j < N_IN; j++) begin
                  rd = read_reg(q.in_map[j], q.ctl, q.ident, MEAS_IN);
                  n.inslot[j] = (IW'(j) < q.in_cnt) ? rd[63:0] : 64'h0;
               end
               n.done = 1'b1;
            end
         end
         default: n.ph = cps_pkg::PH_SNAP;
      endcase
      // nonvolatile save follows any applied setpoint while enabled
      n.ctl.sp_save = sp_hit && (n.ctl.persist != 16'h0000);
      // the setpoint that the loop follows depends on the mode
      n.ctl.active_sp = (n.ctl.mode == cps_pkg::MODE_PRESSURE) ?
                        n.ctl.pres_sp : n.ctl.flow_sp;
      // a new error in the clearing cycle survives: set beats clear
      n.ctl.hw_err_state = (q.ctl.hw_err_state & ~clr_v) |
                           MEAS_IN.hw_err_set;
   end

   // ==========================================================
   // registers
   // reset leaves every output register locked
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         q <= STATE_RST;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // outputs
   assign IN_SLOT_OUT = q.inslot;
   assign SLOT_DONE_OUT = q.done;
   assign CTL_OUT = q.ctl;
   assign WR_MASK_OUT = q.mask;
   assign RUN_OUT = (q.ph == cps_pkg::PH_RUN);
   assign CFG_ERR_OUT = q.cfg_err;
endmodule : cps_regbank

/* File: cps_regbank_properties.sv */
/*
 * port checks of the process-data register bank.
 * assumes: bound into cps_regbank; slot maps held steady between configs.
 */
module cps_regbank_properties #(
   parameter int unsigned N_IN = 20,
   parameter int unsigned N_OUT = 12
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CFG_STB_IN,
   input wire logic [$clog2(N_IN+1)-1:0] IN_CNT_IN,
   input wire logic [$clog2(N_OUT+1)-1:0] OUT_CNT_IN,
   input wire logic [N_OUT-1:0][15:0] OUT_MAP_IN,
   input wire logic CYC_STB_IN,
   input wire logic [N_OUT-1:0][31:0] OUT_SLOT_IN,
   input wire logic SLOT_DONE_OUT,
   input wire cps_pkg::cps_ctl_t CTL_OUT,
   input wire logic [12:0] WR_MASK_OUT,
   input wire logic RUN_OUT,
   input wire logic CFG_ERR_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // helpers
   logic xchg;
   logic [12:0] mask_slot;
   assign xchg = CYC_STB_IN && RUN_OUT && !CFG_STB_IN;
   assign mask_slot = OUT_SLOT_IN[0][12:0];
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // mask watched in sub-slot 0 only, a duplicate elsewhere would mislead
   sequence mask_xchg_s;
      xchg && OUT_MAP_IN[0] == cps_pkg::ADDR_WRITE_ENABLE_MASK
      && OUT_CNT_IN != '0;
   endsequence
   sequence flow_locked_s;
      xchg ##1 !WR_MASK_OUT[1];
   endsequence
   // ==========
   // assertions
   done_after_xchg_a: assert property (xchg |=> SLOT_DONE_OUT)
      else $error("slot done missing after exchange");
   done_has_cause_a: assert property (
      SLOT_DONE_OUT |-> $past(CYC_STB_IN))
      else $error("slot done without exchange");
   in_cnt_refuse_a: assert property (
      CFG_STB_IN && IN_CNT_IN > N_IN |=> CFG_ERR_OUT && !RUN_OUT)
      else $error("oversized input slot accepted");
   out_cnt_refuse_a: assert property (
      CFG_STB_IN && OUT_CNT_IN > N_OUT |=> CFG_ERR_OUT && !RUN_OUT)
      else $error("oversized output slot accepted");
   mask_take_a: assert property (
      mask_xchg_s |=> WR_MASK_OUT == $past(mask_slot))
      else $error("mask not taken from its sub-slot");
   mask_hold_a: assert property (
      !CYC_STB_IN && !CFG_STB_IN |=> $stable(WR_MASK_OUT))
      else $error("mask changed without exchange");
   flow_gate_a: assert property (
      flow_locked_s |-> $stable(CTL_OUT.flow_sp))
      else $error("flow setpoint moved while disabled");
   restart_gate_a: assert property (
      CTL_OUT.soft_restart |-> SLOT_DONE_OUT && WR_MASK_OUT[12])
      else $error("restart pulse without enabled exchange");
   active_sp_a: assert property (
      CTL_OUT.active_sp == (CTL_OUT.mode == cps_pkg::MODE_PRESSURE ?
      CTL_OUT.pres_sp : CTL_OUT.flow_sp))
      else $error("active setpoint does not follow mode");
endmodule : cps_regbank_properties

bind cps_regbank cps_regbank_properties #(.N_IN(N_IN), .N_OUT(N_OUT)) chk_u (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CFG_STB_IN(CFG_STB_IN),
   .IN_CNT_IN(IN_CNT_IN), .OUT_CNT_IN(OUT_CNT_IN), .OUT_MAP_IN(OUT_MAP_IN),
   .CYC_STB_IN(CYC_STB_IN), .OUT_SLOT_IN(OUT_SLOT_IN),
   .SLOT_DONE_OUT(SLOT_DONE_OUT), .CTL_OUT(CTL_OUT),
   .WR_MASK_OUT(WR_MASK_OUT), .RUN_OUT(RUN_OUT), .CFG_ERR_OUT(CFG_ERR_OUT));

/* File: cps_plc_model.sv */
/*
 * behavioural fieldbus controller: slot configuration and output sub-slots.
 * assumes: shares the bank's clock; the bench calls its tasks in turn.
 */
module cps_plc_model (
   input wire logic clk_in,
   output logic cfg_stb_out,
   output logic [4:0] in_cnt_out,
   output logic [3:0] out_cnt_out,
   output logic [19:0][15:0] in_map_out,
   output logic [11:0][15:0] out_map_out,
   output logic cyc_stb_out,
   output logic [11:0][31:0] out_slot_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // output sub-slot map deliberately out of address order, input map in order
   initial begin
      cfg_stb_out = 1'b0;
      cyc_stb_out = 1'b0;
      in_cnt_out = 5'h00;
      out_cnt_out = 4'h0;
      in_map_out = '0;
      in_map_out[0] = cps_pkg::ADDR_FLOW_SETPOINT;
      in_map_out[1] = cps_pkg::ADDR_ALARM_BITMAP;
      in_map_out[2] = cps_pkg::ADDR_SERIAL_NUMBER;
      out_map_out = {12{cps_pkg::ADDR_CAL_TABLE}};
      out_map_out[0] = cps_pkg::ADDR_WRITE_ENABLE_MASK;
      out_map_out[1] = cps_pkg::ADDR_FLOW_SETPOINT;
      out_map_out[2] = cps_pkg::ADDR_SOFTWARE_RESTART;
      out_map_out[3] = cps_pkg::ADDR_HW_ERROR_CLEAR;
      out_map_out[4] = cps_pkg::ADDR_CONTROL_MODE;
      out_map_out[5] = cps_pkg::ADDR_PRESSURE_SETPOINT;
      out_slot_out = '0;
   end
   // ==========
   // configuration and cyclic exchange
   task automatic configure(input logic [4:0] ic, input logic [3:0] oc);
      @(posedge clk_in);
      in_cnt_out <= ic;
      out_cnt_out <= oc;
      cfg_stb_out <= 1'b1;
      @(posedge clk_in);
      cfg_stb_out <= 1'b0;
   endtask : configure
   // released lines show the inverse so stale data cannot pass
   task automatic exchange(input logic [5:0][31:0] v);
      @(posedge clk_in);
      out_slot_out[5:0] <= v;
      cyc_stb_out <= 1'b1;
      @(posedge clk_in);
      cyc_stb_out <= 1'b0;
      out_slot_out <= ~out_slot_out;
   endtask : exchange
endmodule : cps_plc_model

/* File: cyclic_process_data_register_map_tb.sv */
/*
 * self-checking bench of the process-data register bank.
 * assumes: cps_pkg, cps_plc_model and the bound checker are compiled.
 */
module cyclic_process_data_register_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_stb, cyc_stb, slot_done, run, cfg_err, en;
   logic [4:0] in_cnt;
   logic [3:0] out_cnt;
   logic [19:0][15:0] in_map;
   logic [11:0][15:0] out_map;
   logic [11:0][31:0] out_slot;
   logic [19:0][63:0] in_slot;
   logic [12:0] wr_mask;
   logic [31:0] fval, fexp, nv;
   cps_pkg::cps_meas_t meas;
   cps_pkg::cps_ident_t ident;
   cps_pkg::cps_ctl_t ctl;
   int err_count = 0;
   int check_count = 0;
   int cyc_count = 0;
   int seed = 36673;
   always #2.5 clk = ~clk;
   cps_plc_model plc_u (.clk_in(clk), .cfg_stb_out(cfg_stb),
      .in_cnt_out(in_cnt), .out_cnt_out(out_cnt), .in_map_out(in_map),
      .out_map_out(out_map), .cyc_stb_out(cyc_stb), .out_slot_out(out_slot));
   cps_regbank dut_u (.CLK_IN(clk), .RST_IN(rst), .CFG_STB_IN(cfg_stb),
      .IN_CNT_IN(in_cnt), .OUT_CNT_IN(out_cnt), .IN_MAP_IN(in_map),
      .OUT_MAP_IN(out_map), .CYC_STB_IN(cyc_stb), .OUT_SLOT_IN(out_slot),
      .MEAS_IN(meas), .IDENT_IN(ident), .IN_SLOT_OUT(in_slot),
      .SLOT_DONE_OUT(slot_done), .CTL_OUT(ctl), .WR_MASK_OUT(wr_mask),
      .RUN_OUT(run), .CFG_ERR_OUT(cfg_err));
   // ==========
   // helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // sub-slots: mask, flow setpoint, restart, error clear; mode and
   // pressure setpoint held at zero
   task automatic xfer(input logic [15:0] m, input logic [31:0] f,
      input logic [15:0] r, input logic [15:0] c);
      plc_u.exchange({64'h0, 16'h0, c, 16'h0, r, f, 16'h0, m});
      #1;
   endtask : xfer
   // acts only when enabled and changed against the last value sent
   function automatic logic [31:0] next_sp(input logic e,
      input logic [31:0] v, input logic [31:0] last, input logic [31:0] cur);
      return (e && v !== last) ? v : cur;
   endfunction : next_sp
   always @(posedge clk) begin
      cyc_count++;
      if (cyc_count == 4000) begin
         err_count++;
         wrap_up();
      end
   end
   // ==========
   // scenarios
   initial begin
      meas = '0;
      ident = '0;
      ident.serial = $random(seed);
      meas.alarms = 16'($random(seed));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // identity already frozen at this edge: later edits stay hidden
      ident.serial <= ~ident.serial;
      #1;
      check(wr_mask, 13'h0000);
      plc_u.configure(5'd3, 4'd4);
      #1;
      check({cfg_err, run}, 2'b01);
      fval = $random(seed);
      xfer(16'h0000, fval, 16'h0, 16'h0);
      check(ctl.flow_sp, 32'h0);
      // same value again: remembered although it was ignored
      xfer(16'he002, fval, 16'h0, 16'h0);
      check(wr_mask, 13'h0002);
      check(ctl.flow_sp, 32'h0);
      fval = ~fval;
      xfer(16'he002, fval, 16'h0, 16'h0);
      check(ctl.flow_sp, fval);
      xfer(16'h1080, fval, 16'h5, 16'h0);
      check({slot_done, ctl.soft_restart}, 2'b11);
      check(in_slot[0], {32'h0, fval});
      check(in_slot[1], {48'h0, meas.alarms});
      check(in_slot[2], {32'h0, ~ident.serial});
      xfer(16'h1080, fval, 16'h5, 16'h0);
      check(ctl.soft_restart, 1'b0);
      @(posedge clk);
      meas.hw_err_set <= 16'h0006;
      @(posedge clk);
      meas.hw_err_set <= 16'h0000;
      #1;
      check(ctl.hw_err_state, 16'h0006);
      xfer(16'h1080, fval, 16'h5, 16'h2);
      check(ctl.hw_err_state, 16'h0004);
      fexp = fval;
      for (int i = 0; i < 24; i++) begin
         en = 1'($random(seed));
         nv = (i % 3 == 0) ? fval : $random(seed);
         xfer({14'h0, en, 1'b0}, nv, 16'h5, 16'h2);
         fexp = next_sp(en, nv, fval, fexp);
         fval = nv;
         check(ctl.flow_sp, fexp);
         check(ctl.active_sp, fexp);
      end
      plc_u.configure(5'd21, 4'd4);
      #1;
      check({cfg_err, run}, 2'b10);
      xfer(16'h0002, 32'h1, 16'h5, 16'h2);
      check(slot_done, 1'b0);
      plc_u.configure(5'd3, 4'd13);
      #1;
      check({cfg_err, run}, 2'b10);
      plc_u.configure(5'd20, 4'd12);
      #1;
      check({cfg_err, run}, 2'b01);
      // mode and pressure setpoint enabled and written in one exchange
      fval = $random(seed);
      plc_u.exchange({fval, 32'h5, 96'h0, 32'h0408});
      #1;
      check({ctl.mode, ctl.active_sp},
         {cps_pkg::MODE_PRESSURE, fval});
      xfer(16'h1fff, 32'h0, 16'h0, 16'h0);
      check(wr_mask, 13'h1fff);
      // reset in mid-run must lock every output register again
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check({run, wr_mask}, 14'h0000);
      wrap_up();
   end
endmodule : cyclic_process_data_register_map_tb
